/* File: hw/txo_core.sv */
// Purpose: Executes table read, timer mode readback and two xor instructions
// Assumes: APB3 slave, program memory answers one cycle after rom_en
// Notes: Commands are issued by writing the command register; writes refused while busy
`timescale 1ns/10ps
`default_nettype none
`include "txo_map.svh"

module txo_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TXO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory port
  output logic [`TXO_ROM_AW-1:0] rom_addr,
  output logic rom_en,
  input wire logic [`TXO_ROM_W-1:0] rom_data
);

  txo_pkg::txo_core_state_t state_ff;
  txo_pkg::txo_core_state_t nxt_state;
  txo_pkg::txo_apb_req_t req;
  txo_pkg::txo_apb_rsp_t rsp;
  logic [7:0] xor_b;
  logic [7:0] xor_res;
  logic xor_zero;
  logic busy;

  function automatic txo_pkg::txo_reg_t decode(input logic [`TXO_ADDR_W-1:0] a);
    txo_pkg::txo_reg_t r;
    r = txo_pkg::TXO_RG_NONE;
    if (a[1:0] != 2'h0)
    begin
      r = txo_pkg::TXO_RG_NONE;
    end
    else if (a >= `TXO_OFS_FILE)
    begin
      if (a < (`TXO_OFS_FILE + 12'(`TXO_FILE_DEPTH * 4)))
      begin
        r = txo_pkg::TXO_RG_FILE;
      end
    end
    else
    begin
      case (a)
        `TXO_OFS_CMD: r = txo_pkg::TXO_RG_CMD;
        `TXO_OFS_WREG: r = txo_pkg::TXO_RG_WREG;
        `TXO_OFS_HPTR: r = txo_pkg::TXO_RG_HPTR;
        `TXO_OFS_HDATA: r = txo_pkg::TXO_RG_HDATA;
        `TXO_OFS_TMODE: r = txo_pkg::TXO_RG_TMODE;
        `TXO_OFS_STATUS: r = txo_pkg::TXO_RG_STATUS;
        default: r = txo_pkg::TXO_RG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [6:0] file_index(input logic [`TXO_ADDR_W-1:0] a);
    return a[8:2];
  endfunction

  function automatic logic op_legal(input logic [2:0] op);
    return (op <= 3'h4);
  endfunction

  assign req.psel = psel;
  assign req.penable = penable;
  assign req.pwrite = pwrite;
  assign req.paddr = paddr;
  assign req.pwdata = pwdata;

  assign busy = (state_ff.state != txo_pkg::TXO_ST_IDLE);

  // Immediate operand or addressed file register
  assign xor_b = (state_ff.op == txo_pkg::TXO_OP_XIM) ? state_ff.operand :
                 state_ff.file_reg[state_ff.operand[6:0]];

  txo_xor u_xor (
    .a(state_ff.working_register),
    .b(xor_b),
    .result(xor_res),
    .zero(xor_zero)
  );

  always_comb
  begin
    txo_pkg::txo_reg_t rg;
    logic [6:0] fidx;
    rg = decode(req.paddr);
    fidx = file_index(req.paddr);
    nxt_state = state_ff;
    nxt_state.rom.en = 1'b0;

    // Setup phase: prepare answer and error
    if (req.psel && !req.penable)
    begin
      nxt_state.prdata = 32'h0000_0000;
      nxt_state.pslverr = 1'b0;
      case (rg)
        txo_pkg::TXO_RG_CMD:
        begin
          nxt_state.prdata[`TXO_CMD_OP_MSB:`TXO_CMD_OP_LSB] = state_ff.op;
          nxt_state.prdata[`TXO_CMD_DEST_BIT] = state_ff.dest;
          nxt_state.prdata[`TXO_CMD_OPND_MSB:`TXO_CMD_OPND_LSB] = state_ff.operand;
          if (req.pwrite && !op_legal(req.pwdata[`TXO_CMD_OP_MSB:`TXO_CMD_OP_LSB]))
          begin
            nxt_state.pslverr = 1'b1;
          end
        end
        txo_pkg::TXO_RG_WREG: nxt_state.prdata[7:0] = state_ff.working_register;
        txo_pkg::TXO_RG_HPTR: nxt_state.prdata[7:0] = state_ff.table_high_pointer;
        txo_pkg::TXO_RG_HDATA:
        begin
          nxt_state.prdata[`TXO_HDATA_W-1:0] = state_ff.table_high_data;
          nxt_state.pslverr = req.pwrite;
        end
        txo_pkg::TXO_RG_TMODE: nxt_state.prdata[7:0] = state_ff.timer_mode_reg;
        txo_pkg::TXO_RG_STATUS:
        begin
          nxt_state.prdata[`TXO_ST_ZERO_BIT] = state_ff.zero;
          nxt_state.prdata[`TXO_ST_BUSY_BIT] = busy;
        end
        txo_pkg::TXO_RG_FILE: nxt_state.prdata[7:0] = state_ff.file_reg[fidx];
        default: nxt_state.pslverr = 1'b1;
      endcase
      if (req.pwrite && busy)
      begin
        nxt_state.pslverr = 1'b1;
      end
    end

    // Access phase: writes take effect here
    if (req.psel && req.penable && req.pwrite && !state_ff.pslverr)
    begin
      case (rg)
        txo_pkg::TXO_RG_CMD:
        begin
          nxt_state.op = txo_pkg::txo_op_t'(req.pwdata[`TXO_CMD_OP_MSB:`TXO_CMD_OP_LSB]);
          nxt_state.dest = req.pwdata[`TXO_CMD_DEST_BIT];
          nxt_state.operand = req.pwdata[`TXO_CMD_OPND_MSB:`TXO_CMD_OPND_LSB];
          if (nxt_state.op == txo_pkg::TXO_OP_TBL)
          begin
            nxt_state.state = txo_pkg::TXO_ST_TBL1;
            nxt_state.rom.en = 1'b1;
            nxt_state.rom.addr = {state_ff.table_high_pointer[`TXO_PTR_MSB:`TXO_PTR_LSB],
                                  state_ff.working_register};
          end
          else if (nxt_state.op != txo_pkg::TXO_OP_NOP)
          begin
            nxt_state.state = txo_pkg::TXO_ST_EXEC;
          end
        end
        txo_pkg::TXO_RG_WREG: nxt_state.working_register = req.pwdata[7:0];
        txo_pkg::TXO_RG_HPTR: nxt_state.table_high_pointer = req.pwdata[7:0];
        txo_pkg::TXO_RG_TMODE: nxt_state.timer_mode_reg = req.pwdata[7:0];
        txo_pkg::TXO_RG_STATUS: nxt_state.zero = req.pwdata[`TXO_ST_ZERO_BIT];
        txo_pkg::TXO_RG_FILE: nxt_state.file_reg[fidx] = req.pwdata[7:0];
        default: nxt_state.zero = state_ff.zero;
      endcase
    end

    // Instruction execution
    case (state_ff.state)
      txo_pkg::TXO_ST_IDLE: nxt_state.state = nxt_state.state;
      txo_pkg::TXO_ST_EXEC:
      begin
        nxt_state.state = txo_pkg::TXO_ST_IDLE;
        case (state_ff.op)
          txo_pkg::TXO_OP_TMR:
          begin
            nxt_state.working_register = state_ff.timer_mode_reg;
          end
          txo_pkg::TXO_OP_XRF:
          begin
            nxt_state.zero = xor_zero;
            if (state_ff.dest)
            begin
              nxt_state.file_reg[state_ff.operand[6:0]] = xor_res;
            end
            else
            begin
              nxt_state.working_register = xor_res;
            end
          end
          txo_pkg::TXO_OP_XIM:
          begin
            nxt_state.zero = xor_zero;
            nxt_state.working_register = xor_res;
          end
          default: nxt_state.state = txo_pkg::TXO_ST_IDLE;
        endcase
      end
      txo_pkg::TXO_ST_TBL1: nxt_state.state = txo_pkg::TXO_ST_TBL2;
      txo_pkg::TXO_ST_TBL2:
      begin
        nxt_state.state = txo_pkg::TXO_ST_IDLE;
        nxt_state.working_register = rom_data[7:0];
        nxt_state.table_high_data = rom_data[`TXO_ROM_W-1:8];
      end
      default: nxt_state.state = txo_pkg::TXO_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= '0;
      state_ff.state <= txo_pkg::TXO_ST_IDLE;
      state_ff.op <= txo_pkg::TXO_OP_NOP;
      state_ff.working_register <= `TXO_RST_WREG;
      state_ff.table_high_pointer <= `TXO_RST_HPTR;
      state_ff.table_high_data <= `TXO_RST_HDATA;
      state_ff.timer_mode_reg <= `TXO_RST_TMODE;
      state_ff.file_reg <= {`TXO_FILE_DEPTH{`TXO_RST_FILE}};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rsp.prdata = state_ff.prdata;
  assign rsp.pready = 1'b1;
  assign rsp.pslverr = psel && penable && state_ff.pslverr;

  assign prdata = rsp.prdata;
  assign pready = rsp.pready;
  assign pslverr = rsp.pslverr;
  assign rom_addr = state_ff.rom.addr;
  assign rom_en = state_ff.rom.en;

endmodule // txo_core

`default_nettype wire

/* File: hw/txo_map.svh */
// Purpose: Register map, field positions and reset values of the table/xor unit
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Included by the package and by the execution unit
`ifndef TXO_MAP_SVH
`define TXO_MAP_SVH

`define TXO_ADDR_W 12
`define TXO_OFS_CMD 12'h000
`define TXO_OFS_WREG 12'h004
`define TXO_OFS_HPTR 12'h008
`define TXO_OFS_HDATA 12'h00C
`define TXO_OFS_TMODE 12'h010
`define TXO_OFS_STATUS 12'h014
`define TXO_OFS_FILE 12'h400
`define TXO_FILE_DEPTH 128

`define TXO_CMD_OP_LSB 0
`define TXO_CMD_OP_MSB 2
`define TXO_CMD_DEST_BIT 3
`define TXO_CMD_OPND_LSB 8
`define TXO_CMD_OPND_MSB 15
`define TXO_ST_ZERO_BIT 0
`define TXO_ST_BUSY_BIT 1

`define TXO_PTR_LSB 0
`define TXO_PTR_MSB 2
`define TXO_HDATA_W 6
`define TXO_ROM_W 14
`define TXO_ROM_AW 11

`define TXO_RST_WREG 8'h00
`define TXO_RST_HPTR 8'h00
`define TXO_RST_HDATA 6'h00
`define TXO_RST_TMODE 8'h00
`define TXO_RST_FILE 8'h00

`endif

/* File: hw/txo_pkg.sv */
// Purpose: Types shared by the table/xor execution unit
// Assumes: txo_map.svh supplies widths
// Notes: Opcodes are what software writes into the command field
`include "txo_map.svh"

package txo_pkg;

  typedef enum logic [2:0] {
    TXO_OP_NOP = 3'h0,
    TXO_OP_TBL = 3'h1,
    TXO_OP_TMR = 3'h2,
    TXO_OP_XRF = 3'h3,
    TXO_OP_XIM = 3'h4
  } txo_op_t;

  typedef enum logic [1:0] {
    TXO_ST_IDLE = 2'h0,
    TXO_ST_EXEC = 2'h1,
    TXO_ST_TBL1 = 2'h2,
    TXO_ST_TBL2 = 2'h3
  } txo_state_t;

  typedef enum logic [2:0] {
    TXO_RG_CMD = 3'h0,
    TXO_RG_WREG = 3'h1,
    TXO_RG_HPTR = 3'h2,
    TXO_RG_HDATA = 3'h3,
    TXO_RG_TMODE = 3'h4,
    TXO_RG_STATUS = 3'h5,
    TXO_RG_FILE = 3'h6,
    TXO_RG_NONE = 3'h7
  } txo_reg_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`TXO_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } txo_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } txo_apb_rsp_t;

  typedef struct packed {
    logic [`TXO_ROM_AW-1:0] addr;
    logic en;
  } txo_rom_req_t;

  typedef struct packed {
    txo_state_t state;
    txo_op_t op;
    logic dest;
    logic [7:0] operand;
    logic [7:0] working_register;
    logic [7:0] table_high_pointer;
    logic [`TXO_HDATA_W-1:0] table_high_data;
    logic [7:0] timer_mode_reg;
    logic zero;
    txo_rom_req_t rom;
    logic [31:0] prdata;
    logic pslverr;
    logic [`TXO_FILE_DEPTH-1:0][7:0] file_reg;
  } txo_core_state_t;

endpackage

/* File: hw/txo_xor.sv */
// Purpose: Byte exclusive-OR with zero detect
// Assumes: Pure combinational
// Notes: Shared by both xor instructions
`timescale 1ns/10ps
`default_nettype none

module txo_xor (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // Result
  output logic [7:0] result,
  output logic zero
);

  assign result = a ^ b;
  assign zero = (result == 8'h00);

endmodule // txo_xor

`default_nettype wire

/* File: verification/txo_core_monitor.sv */
// Purpose: Port-level checks of txo_core
// Assumes: Zero-wait APB slave, one-cycle fetch strobe
// Notes: Bound to every txo_core below
`timescale 1ns/10ps
`default_nettype none
`include "txo_map.svh"
module txo_core_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TXO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Program memory
  input wire logic [`TXO_ROM_AW-1:0] rom_addr,
  input wire logic rom_en,
  input wire logic [`TXO_ROM_W-1:0] rom_data
);
  logic wr_acc;
  logic cmd_wr;
  logic cmd_ok;
  logic tbl_go;
  assign wr_acc = psel && penable && pwrite;
  assign cmd_wr = wr_acc && paddr == `TXO_OFS_CMD;
  assign cmd_ok = cmd_wr && !pslverr;
  assign tbl_go = cmd_ok && pwdata[2:0] == 3'h1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_table_fetch: assert property (tbl_go |=> rom_en)
    else $error("table read without fetch");
  a_fetch_cause: assert property (rom_en |-> $past(tbl_go))
    else $error("fetch without table read");
  a_fetch_once: assert property (rom_en |=> !rom_en)
    else $error("fetch strobe too long");
  a_table_busy: assert property (tbl_go ##2 wr_acc |-> pslverr)
    else $error("write taken during table read");
  a_xor_no_fetch: assert property (cmd_ok && pwdata[2:0] > 3'h1 |=> !rom_en [*2])
    else $error("single-cycle op fetched");
  a_hdata_ro: assert property (wr_acc && paddr == `TXO_OFS_HDATA |-> pslverr)
    else $error("high data write taken");
  a_bad_op: assert property (cmd_wr && pwdata[2:0] > 3'h4 |-> pslverr)
    else $error("unknown op taken");
  a_file_end: assert property (psel && penable && paddr == 12'h600 |-> pslverr)
    else $error("file index past 127 taken");
  c_table: cover property (tbl_go);
  c_nop: cover property (cmd_ok && pwdata[2:0] == 3'h0);
  c_xor: cover property (cmd_ok && pwdata[2:0] == 3'h4);
  c_refuse: cover property (pslverr);
endmodule // txo_core_monitor
bind txo_core txo_core_monitor u_txo_core_monitor (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rom_addr(rom_addr), .rom_en(rom_en), .rom_data(rom_data)
);
`default_nettype wire

/* File: verification/txo_core_tb.sv */
// Purpose: Self-checking bench for txo_core
// Assumes: Zero-wait APB, program word valid the cycle after the strobe
// Notes: Program memory is a fixed function of the address
`timescale 1ns/10ps
`default_nettype none
`include "txo_map.svh"
module txo_core_tb;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, rom_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] rom_addr, seen_addr;
  logic [13:0] rom_data, w;
  int n_mismatch, check_count, n_fetch;
  txo_core u_txo_core (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rom_addr(rom_addr), .rom_en(rom_en), .rom_data(rom_data));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [13:0] rom_word(input logic [10:0] a);
    return {a[5:0], a[7:0]} ^ 14'h2A5A;
  endfunction
  function automatic logic [31:0] cmd(input txo_pkg::txo_op_t op, input logic d,
    input logic [7:0] o);
    return {16'h0, o, 4'h0, d, op};
  endfunction
  // Outside the fetch cycle the word is inverted so an early or late sample never matches
  always @(posedge clk)
  begin
    rom_data <= rom_en ? rom_word(rom_addr) : ~rom_word(rom_addr);
    if (rom_en === 1'b1)
    begin
      n_fetch <= n_fetch + 1;
      seen_addr <= rom_addr;
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic wt, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    // Values seen here are those that stood up to this edge
    rd = prdata;
    err = pslverr;
  endtask
  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle;
  endtask
  task rdc(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    idle;
    chk(n, rd, x);
  endtask
  task t_table;
    wr(`TXO_OFS_STATUS, 32'h1);
    wr(`TXO_OFS_HPTR, 32'hFA);
    wr(`TXO_OFS_WREG, 32'h34);
    apb(1'b1, `TXO_OFS_CMD, cmd(txo_pkg::TXO_OP_TBL, 1'b0, 8'h00));
    apb(1'b1, `TXO_OFS_WREG, 32'h77);
    idle;
    chk("busy_refuse", {31'h0, err}, 32'h1);
    w = rom_word(11'h234);
    chk("fetch_addr", {21'h0, seen_addr}, 32'h234);
    chk("fetch_count", n_fetch, 32'h1);
    rdc("tbl_low", `TXO_OFS_WREG, {24'h0, w[7:0]});
    rdc("tbl_high", `TXO_OFS_HDATA, {26'h0, w[13:8]});
    rdc("tbl_flags", `TXO_OFS_STATUS, 32'h1);
    wr(`TXO_OFS_HDATA, 32'h3F);
    chk("hdata_ro", {31'h0, err}, 32'h1);
  endtask
  task t_timer;
    for (int i = 0; i < 2; i++)
    begin
      wr(`TXO_OFS_TMODE, i ? 32'h0 : 32'h55);
      wr(`TXO_OFS_WREG, 32'hAA);
      wr(`TXO_OFS_STATUS, i ? 32'h0 : 32'h1);
      wr(`TXO_OFS_CMD, cmd(txo_pkg::TXO_OP_TMR, 1'b0, 8'h00));
      rdc("tmr_wreg", `TXO_OFS_WREG, i ? 32'h0 : 32'h55);
      rdc("tmr_flags", `TXO_OFS_STATUS, i ? 32'h0 : 32'h1);
    end
  endtask
  task xcase(input txo_pkg::txo_op_t op, input logic d, input logic [6:0] ix,
    input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [11:0] fa;
    logic rf;
    r = a ^ b;
    fa = 12'h400 + {3'h0, ix, 2'h0};
    rf = op == txo_pkg::TXO_OP_XRF;
    // Preset the flag to the wrong value so a missed update shows
    wr(`TXO_OFS_STATUS, {31'h0, |r});
    wr(`TXO_OFS_WREG, {24'h0, a});
    if (rf)
      wr(fa, {24'h0, b});
    wr(`TXO_OFS_CMD, cmd(op, d, rf ? {1'b0, ix} : b));
    rdc("xor_wreg", `TXO_OFS_WREG, {24'h0, rf && d ? a : r});
    if (rf)
      rdc("xor_file", fa, {24'h0, d ? r : b});
    rdc("xor_zero", `TXO_OFS_STATUS, {31'h0, ~|r});
  endtask
  task t_err;
    for (int i = 5; i < 8; i++)
    begin
      wr(`TXO_OFS_CMD, i);
      chk("bad_op", {31'h0, err}, 32'h1);
    end
    apb(1'b0, 12'h600, 32'h0);
    idle;
    chk("file_end", {31'h0, err}, 32'h1);
    // A no-operation command is stored but starts nothing
    wr(`TXO_OFS_CMD, cmd(txo_pkg::TXO_OP_NOP, 1'b0, 8'h5A));
    rdc("nop_cmd", `TXO_OFS_CMD, 32'h0000_5A00);
    rdc("nop_idle", `TXO_OFS_STATUS, 32'h1);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 1; i < 6; i++)
      rdc("reset", 12'(4 * i), 32'h0);
    rdc("reset_file", 12'h5FC, 32'h0);
    t_table;
    t_timer;
    xcase(txo_pkg::TXO_OP_XRF, 1'b1, 7'h7F, 8'hF0, 8'hA5);
    xcase(txo_pkg::TXO_OP_XRF, 1'b0, 7'h00, 8'h5A, 8'h5A);
    xcase(txo_pkg::TXO_OP_XIM, 1'b1, 7'h00, 8'hF0, 8'hA5);
    xcase(txo_pkg::TXO_OP_XIM, 1'b0, 7'h00, 8'hFF, 8'hFF);
    t_err;
    wrap_up;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule // txo_core_tb
`default_nettype wire
